/* File: hdl/dsc_chan.sv */
// One converter channel: acquisition, hold, binary search and output coding
`timescale 1ns/10ps
module dsc_chan (
  input wire logic clk,
  input wire logic reset_n,
  dsc_chan_if.ctrl ch
);
  import dsc_pkg::*;
  dsc_state_t state;
  logic start_d;
  logic [ACQ_CNT_W-1:0] acq_cnt;
  logic [BIT_IDX_W-1:0] bit_idx;
  logic [RESULT_W-1:0] trial;
  logic over_seen;
  logic under_seen;
  logic start_rise;
  assign start_rise = ch.start & ~start_d;

  // ==========================================================
  // Sequencer
  // Start edge history for edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) start_d <= 1'b0;
    else start_d <= ch.start;
  end

  // State moves; start ignored outside a completed acquisition
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_POWER_DOWN;
    end else begin
      case (state)
        ST_POWER_DOWN: begin
          if (start_rise) state <= ST_OPEN_GND;
        end
        ST_ACQUIRE: begin
          if (acq_cnt == ACQ_LAST) state <= ST_POWER_DOWN;
        end
        ST_OPEN_GND: state <= ST_HOLD;
        ST_HOLD: state <= ST_SEARCH;
        ST_SEARCH: begin
          if (bit_idx == LSB_IDX) state <= ST_FINISH;
        end
        ST_FINISH: state <= ST_ACQUIRE;
        default: state <= ST_POWER_DOWN;
      endcase
    end
  end

  // Acquisition settle counter; a start before it ends is not honoured
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) acq_cnt <= ACQ_ZERO;
    else if (state == ST_ACQUIRE) acq_cnt <= acq_cnt + 1'b1;
    else acq_cnt <= ACQ_ZERO;
  end

  // ==========================================================
  // Binary search, MSB first, one step per internal clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_idx <= MSB_IDX;
      trial <= CODE_RESET;
    end else if (state == ST_HOLD) begin
      bit_idx <= MSB_IDX;
      trial <= SIGN_FLIP; // Largest element switched to reference first
    end else if (state == ST_SEARCH) begin
      // Comparator high keeps the trial bit; then try the next lower
      if (!ch.comp_high) trial[bit_idx] <= 1'b0;
      if (bit_idx != LSB_IDX) begin
        trial[bit_idx - 1'b1] <= 1'b1;
        bit_idx <= bit_idx - 1'b1;
      end
    end else begin
      trial <= CODE_RESET; // Array idle outside a search
    end
  end

  // Array shows the live trial, so the comparator judges the bit now under
  assign ch.dac_bits = trial;

  // Range flags caught during hold so saturation tracks this sample
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      over_seen <= 1'b0;
      under_seen <= 1'b0;
    end else if (state == ST_HOLD) begin
      over_seen <= ch.over_range;
      under_seen <= ch.under_range;
    end
  end

  // ==========================================================
  // Output code: offset binary to two's complement, with saturation
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ch.code <= CODE_RESET;
      ch.done <= 1'b0;
    end else begin
      ch.done <= (state == ST_FINISH);
      if (state == ST_FINISH) begin
        if (over_seen) ch.code <= CODE_POS_SAT;
        else if (under_seen) ch.code <= CODE_NEG_SAT;
        else ch.code <= trial ^ SIGN_FLIP;
      end
    end
  end

  // Switch drive and status from state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ch.pos_gnd_sw <= 1'b1;
      ch.neg_gnd_sw <= 1'b1;
      ch.input_conn <= 1'b1;
      ch.busy <= 1'b0;
      ch.powered <= 1'b0;
    end else begin
      // Ground switches open first, inputs released one cycle later
      ch.pos_gnd_sw <= (state == ST_POWER_DOWN) || (state == ST_ACQUIRE) ||
                       (state == ST_FINISH);
      ch.neg_gnd_sw <= (state == ST_POWER_DOWN) || (state == ST_ACQUIRE) ||
                       (state == ST_FINISH);
      ch.input_conn <= !((state == ST_HOLD) || (state == ST_SEARCH));
      ch.busy <= (state == ST_OPEN_GND) || (state == ST_HOLD) || (state == ST_SEARCH);
      ch.powered <= (state != ST_POWER_DOWN);
    end
  end
endmodule : dsc_chan

/* File: hdl/dsc_pkg.sv */
// Constants and types shared by the dual converter control block
package dsc_pkg;
  // ==========================================================
  // Widths and codes
  localparam int RESULT_W = 16;
  localparam int BIT_IDX_W = 4;
  localparam logic [3:0] MSB_IDX = 4'hf;
  localparam logic [3:0] LSB_IDX = 4'h0;
  localparam logic [15:0] CODE_POS_SAT = 16'h7fff;
  localparam logic [15:0] CODE_NEG_SAT = 16'h8000;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;
  // ==========================================================
  // Timing: acquisition time before a new start is honoured
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACQ_TIME_NS = 290;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CNT_W = 6;
  localparam logic [5:0] ACQ_LAST = ACQ_CNT_W'(ACQ_CYCLES - 1);
  localparam logic [5:0] ACQ_ZERO = 6'h00;
  // ==========================================================
  // Channel sequencer states, Gray in declaration order
  typedef enum logic [2:0] {
    ST_POWER_DOWN = 3'b000,
    ST_ACQUIRE = 3'b001,
    ST_OPEN_GND = 3'b011,
    ST_HOLD = 3'b010,
    ST_SEARCH = 3'b110,
    ST_FINISH = 3'b111
  } dsc_state_t;
endpackage : dsc_pkg

/* File: hdl/dsc_chan_if.sv */
// Interface carrying one channel's control and result signals
`timescale 1ns/10ps
interface dsc_chan_if;
  import dsc_pkg::*;
  logic start;
  logic comp_high;
  logic over_range;
  logic under_range;
  logic pos_gnd_sw;
  logic neg_gnd_sw;
  logic input_conn;
  logic [RESULT_W-1:0] dac_bits;
  logic busy;
  logic powered;
  logic done;
  logic [RESULT_W-1:0] code;
  modport ctrl (input start, comp_high, over_range, under_range,
                output pos_gnd_sw, neg_gnd_sw, input_conn, dac_bits, busy, powered, done, code);
  modport top (output start, comp_high, over_range, under_range,
               input pos_gnd_sw, neg_gnd_sw, input_conn, dac_bits, busy, powered, done, code);
endinterface : dsc_chan_if

/* File: hdl/dsc_top.sv */
// Top level: two independent converter channels with synchronised starts
`timescale 1ns/10ps
// Behaviour
// - A rising convert start after acquisition has completed begins a conversion.
// - Conversion first opens the array ground switches, then moves arrays from inputs to ground.
// - A 16-step binary search runs MSB first over binary-weighted elements.
// - After the search the channel returns to acquisition and delivers code and busy status.
// - The internal clock times the steps; the serial shift clock plays no part.
// - Each result belongs to its own sample with no pipeline latency.
// - Both channels convert concurrently, each up to about two million samples per second.
// - Each channel powers down between conversions.
// - The output code is two's complement with midscale at zero.
// - Over-range input saturates at the largest positive code.
// - Under-range input saturates at the most negative code.
// - A started conversion completes whatever the convert start does later.
module dsc_top (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [1:0] CONVERT_START_INPUT,
  input wire logic [1:0] COMP_HIGH,
  input wire logic [1:0] OVER_RANGE,
  input wire logic [1:0] UNDER_RANGE,
  output logic [1:0] POS_ARRAY_GROUND_SWITCH,
  output logic [1:0] NEG_ARRAY_GROUND_SWITCH,
  output logic [1:0] INPUT_CONNECT,
  output logic [1:0] BUSY,
  output logic [1:0] POWERED,
  output logic [1:0] RESULT_VALID,
  output logic [dsc_pkg::RESULT_W-1:0] DAC_BITS [2],
  output logic [dsc_pkg::RESULT_W-1:0] RESULT [2]
);
  import dsc_pkg::*;
  // ==========================================================
  // Start pins come from outside, so two flops before any logic
  logic [1:0] start_s1;
  logic [1:0] start_s2;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      start_s1 <= 2'h0;
      start_s2 <= 2'h0;
    end else begin
      start_s1 <= CONVERT_START_INPUT;
      start_s2 <= start_s1;
    end
  end

  // ==========================================================
  // Two channels, fully independent so both may run at once
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      dsc_chan_if chif ();
      assign chif.start = start_s2[g];
      assign chif.comp_high = COMP_HIGH[g]; // Same-clock analog model, no sync
      assign chif.over_range = OVER_RANGE[g];
      assign chif.under_range = UNDER_RANGE[g];
      dsc_chan u_chan (.clk(CLK), .reset_n(RESET_N), .ch(chif));
      assign POS_ARRAY_GROUND_SWITCH[g] = chif.pos_gnd_sw;
      assign NEG_ARRAY_GROUND_SWITCH[g] = chif.neg_gnd_sw;
      assign INPUT_CONNECT[g] = chif.input_conn;
      assign BUSY[g] = chif.busy;
      assign POWERED[g] = chif.powered;
      assign RESULT_VALID[g] = chif.done;
      assign DAC_BITS[g] = chif.dac_bits;
      assign RESULT[g] = chif.code;
    end
  endgenerate
endmodule : dsc_top

/* File: bench/dsc_cmp_model.sv */
// Comparator and range-detect model standing at one channel's analog side
`timescale 1ns/10ps
module dsc_cmp_model (
  input wire logic [15:0] dac_bits,
  input wire logic [15:0] level,
  input wire logic ovr,
  input wire logic und,
  output logic comp_high,
  output logic over_range,
  output logic under_range
);
  // ====
  // Held sample as offset binary; trial kept while not above it
  assign comp_high = (dac_bits <= level);
  // Range flags come straight from the bench
  assign over_range = ovr;
  assign under_range = und;
endmodule : dsc_cmp_model

/* File: bench/dsc_top_properties.sv */
// Concurrent checks on the dual converter control ports
`timescale 1ns/10ps
module dsc_top_props (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [1:0] POS_ARRAY_GROUND_SWITCH,
  input wire logic [1:0] NEG_ARRAY_GROUND_SWITCH,
  input wire logic [1:0] INPUT_CONNECT,
  input wire logic [1:0] BUSY,
  input wire logic [1:0] POWERED,
  input wire logic [1:0] RESULT_VALID,
  input wire logic [dsc_pkg::RESULT_W-1:0] DAC_BITS [2],
  input wire logic [dsc_pkg::RESULT_W-1:0] RESULT [2]
);
  // ====
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  valid_pulse_a: assert property (RESULT_VALID[0] |=> !RESULT_VALID[0])
    else $error("result valid longer than one cycle");
  gnd_first_a: assert property ($fell(POS_ARRAY_GROUND_SWITCH[0]) |->
    INPUT_CONNECT[0] && !NEG_ARRAY_GROUND_SWITCH[0]) else $error("inputs left before switches");
  hold_order_a: assert property ($fell(INPUT_CONNECT[0]) |->
    !POS_ARRAY_GROUND_SWITCH[0] && !NEG_ARRAY_GROUND_SWITCH[0]) else $error("hold with switch shut");
  msb_first_a: assert property ($fell(INPUT_CONNECT[0]) |-> ##[0:2] DAC_BITS[0] == 16'h8000)
    else $error("first trial is not the top bit");
  done_bound_a: assert property ($rose(BUSY[0]) |-> ##[16:24] RESULT_VALID[0])
    else $error("conversion did not finish in time");
  busy_hold_a: assert property ($rose(BUSY[1]) |-> BUSY[1][*8])
    else $error("conversion cut short");
  result_stable_a: assert property (!RESULT_VALID[0] |-> $stable(RESULT[0]))
    else $error("result moved without valid");
  powered_a: assert property (BUSY[1] |-> POWERED[1])
    else $error("busy while powered down");
  valid_acq_a: assert property (RESULT_VALID[1] |-> INPUT_CONNECT[1] && !BUSY[1])
    else $error("result before return to acquisition");
endmodule : dsc_top_props
bind dsc_top dsc_top_props chk_u (.CLK(CLK), .RESET_N(RESET_N),
  .POS_ARRAY_GROUND_SWITCH(POS_ARRAY_GROUND_SWITCH),
  .NEG_ARRAY_GROUND_SWITCH(NEG_ARRAY_GROUND_SWITCH), .INPUT_CONNECT(INPUT_CONNECT),
  .BUSY(BUSY), .POWERED(POWERED), .RESULT_VALID(RESULT_VALID), .DAC_BITS(DAC_BITS),
  .RESULT(RESULT));

/* File: bench/testbench.sv */
// Self-checking bench for the dual converter control block
`timescale 1ns/10ps
module testbench;
  import dsc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] start = 2'b00;
  logic [15:0] level [2] = '{16'h8000, 16'h8000};
  logic [1:0] ovr = 2'b00;
  logic [1:0] und = 2'b00;
  wire [1:0] comp;
  wire [1:0] over;
  wire [1:0] under;
  logic [1:0] pos_sw, neg_sw, in_conn, busy, powered, valid;
  logic [15:0] dac [2];
  logic [15:0] result [2];
  int errors = 0;
  int num_checks = 0;
  // ====
  // Clock, 10 ns period
  always #5 clk = ~clk;
  dsc_top dut_u (.CLK(clk), .RESET_N(reset_n), .CONVERT_START_INPUT(start), .COMP_HIGH(comp),
    .OVER_RANGE(over), .UNDER_RANGE(under), .POS_ARRAY_GROUND_SWITCH(pos_sw),
    .NEG_ARRAY_GROUND_SWITCH(neg_sw), .INPUT_CONNECT(in_conn), .BUSY(busy),
    .POWERED(powered), .RESULT_VALID(valid), .DAC_BITS(dac), .RESULT(result));
  // One comparator model per channel
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    dsc_cmp_model cmp_u (.dac_bits(dac[i]), .level(level[i]), .ovr(ovr[i]), .und(und[i]),
      .comp_high(comp[i]), .over_range(over[i]), .under_range(under[i]));
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // Waits for valid on the lowest started channel, then idles past acquisition
  task automatic convert(input logic [1:0] m, input logic [15:0] e0, input logic [15:0] e1);
    int n;
    @(negedge clk) start = m;
    repeat (3) @(negedge clk);
    start = 2'b00;
    for (n = 0; n < 40 && valid[m[0] ? 0 : 1] !== 1'b1; n++) @(negedge clk);
    if (m[0]) begin
      check({15'h0, valid[0]}, 16'h0001);
      check(result[0], e0);
    end
    if (m[1]) begin
      check({15'h0, valid[1]}, 16'h0001);
      check(result[1], e1);
    end
    repeat (50) @(negedge clk);
  endtask : convert
  // Boundary codes on both channels at once, mirrored order
  task automatic code_table();
    logic [15:0] t [6] = '{16'h0000, 16'h0001, 16'hffff, 16'h8001, 16'h7fff, 16'h8000};
    for (int k = 0; k < 6; k++) begin
      level[0] = t[k] ^ SIGN_FLIP;
      level[1] = t[5 - k] ^ SIGN_FLIP;
      convert(2'b11, t[k], t[5 - k]);
    end
  endtask : code_table
  // Range flags win over a midscale search
  task automatic range_sat();
    level = '{16'h8000, 16'h8000};
    ovr = 2'b01;
    und = 2'b10;
    convert(2'b11, 16'h7fff, 16'h8000);
    ovr = 2'b00;
    und = 2'b00;
  endtask : range_sat
  // Starts during conversion and acquisition are dropped
  task automatic ignored_starts();
    int n;
    level[1] = 16'h1234;
    @(negedge clk) start = 2'b10;
    repeat (3) @(negedge clk);
    start = 2'b00;
    repeat (3) @(negedge clk);
    start = 2'b10;
    repeat (3) @(negedge clk);
    start = 2'b00;
    for (n = 0; n < 40 && valid[1] !== 1'b1; n++) @(negedge clk);
    check(result[1], 16'h9234);
    @(negedge clk) start = 2'b10;
    for (n = 0; n < 40; n++) begin
      @(negedge clk) start = 2'b00;
      if (valid[1] !== 1'b0) check({15'h0, valid[1]}, 16'h0000);
    end
    check({15'h0, powered[1]}, 16'h0000);
    level[1] = 16'h4321;
    convert(2'b10, 16'h0000, 16'hc321);
  endtask : ignored_starts
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    code_table();
    range_sat();
    ignored_starts();
    complete_run();
  end
  // Watchdog, well beyond a dozen conversions
  initial begin
    #50000;
    errors++;
    complete_run();
  end
endmodule : testbench
